// file: logic/lcs_pkg.sv
package lcs_pkg;

    // ==========================================================
    // Address widths and decode targets
    // ==========================================================
    localparam int ADDR_W = 24;
    localparam logic [15:0] POST_PORT_ADDR = 16'h0080;
    localparam logic [15:0] KBC_DATA_ADDR = 16'h0060;
    localparam logic [15:0] KBC_CMD_ADDR = 16'h0064;
    localparam logic [15:0] AUX_DATA_ADDR = 16'h0062;
    localparam logic [15:0] AUX_CMD_ADDR = 16'h0066;
    localparam logic [15:0] RTC_INDEX_ADDR = 16'h0070;
    localparam logic [15:0] RTC_DATA_ADDR = 16'h0071;
    localparam int LOW_IO_TOP_BIT = 15;
    localparam int LOW_IO_BOT_BIT = 11;

    // ==========================================================
    // BIOS decode range encodings
    // ==========================================================
    localparam logic [1:0] BIOS_RANGE_1MB = 2'h0;
    localparam logic [1:0] BIOS_RANGE_2MB = 2'h1;
    localparam logic [1:0] BIOS_RANGE_4MB = 2'h2;
    localparam logic [1:0] BIOS_RANGE_8MB = 2'h3;

    // ==========================================================
    // Multiplexed pin positions
    // ==========================================================
    localparam int PIN_KB_IRQ = 0;
    localparam int PIN_KB_SEL = 1;
    localparam int PIN_AUX_SEL = 2;
    localparam int PIN_PROG_IRQ = 3;
    localparam int PIN_POWER_LED = 4;
    localparam int PIN_RTC_IRQ = 5;
    localparam int PIN_RTC_SEL = 6;
    localparam int PIN_LOW_IO = 7;
    localparam int PIN_COUNT = 8;

    // ==========================================================
    // Values after reset
    // ==========================================================
    localparam logic SELECT_IDLE = 1'b1;
    localparam logic POWER_LED_RESET = 1'b0;
    localparam logic [7:0] PIN_STATUS_RESET = 8'h00;

    // ==========================================================
    // Reference clock figures
    // ==========================================================
    localparam real REF_CLOCK_MHZ = 14.318;
    localparam real AUX_CLOCK_DEFAULT_MHZ = 24.576;
    localparam real AUX_CLOCK_ALT_MHZ = 25.000;

endpackage : lcs_pkg

// file: logic/lcs_pin_mux.sv
`timescale 1ns/1ps
module lcs_pin_mux
    import lcs_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [ADDR_WIDTH-1:0] isa_addr,
    input wire logic isa_ior_n,
    input wire logic isa_iow_n,
    input wire logic isa_memr_n,
    input wire logic isa_memw_n,
    input wire logic rom_decode_enable,
    input wire logic [1:0] bios_range_sel,
    input wire logic bios_write_enable,
    input wire logic gpio_activation_enable,
    input wire logic low_io_select_enable,
    input wire logic prog_irq_select,
    input wire logic power_indicator_select,
    input wire logic power_indicator_write,
    input wire logic power_indicator_level,
    input wire logic [PIN_COUNT-1:0] gpio_out_value,
    input wire logic [PIN_COUNT-1:0] gpio_drive_enable,
    input wire logic post_pin_in,
    output logic post_pin_out,
    output logic post_pin_oe,
    input wire logic rom_pin_in,
    output logic rom_pin_out,
    output logic rom_pin_oe,
    input wire logic clock_strap_n,
    input wire logic aux_clock_pin_in,
    output logic aux_clock_select_25m,
    input wire logic [PIN_COUNT-1:0] gpio_pin_in,
    output logic [PIN_COUNT-1:0] gpio_pin_out,
    output logic [PIN_COUNT-1:0] gpio_pin_oe,
    output logic [PIN_COUNT-1:0] gpio_in_value,
    output logic [PIN_COUNT-1:0] pin_function_status,
    output logic keyboard_irq_out,
    output logic clock_irq_out,
    output logic programmable_irq_input,
    input wire logic ref_clock_in,
    output logic ref_clock_buffer_out,
    output logic ref_clock_buffer_out_2
);

    // ==========================================================
    // Decode helpers
    // ==========================================================
    function automatic logic io_match(input logic [ADDR_WIDTH-1:0] addr,
                                      input logic [15:0] target);
        io_match = (addr[15:0] == target);
    endfunction : io_match

    function automatic logic bios_match(input logic [ADDR_WIDTH-1:0] addr,
                                        input logic [1:0] range);
        logic hit;
        hit = 1'b0;
        unique case (range)
            BIOS_RANGE_1MB: hit = &addr[ADDR_WIDTH-1:ADDR_WIDTH-4];
            BIOS_RANGE_2MB: hit = &addr[ADDR_WIDTH-1:ADDR_WIDTH-3];
            BIOS_RANGE_4MB: hit = &addr[ADDR_WIDTH-1:ADDR_WIDTH-2];
            BIOS_RANGE_8MB: hit = addr[ADDR_WIDTH-1];
        endcase
        bios_match = hit;
    endfunction : bios_match

    logic io_cycle;
    logic io_write;
    logic mem_cycle;
    assign io_write = !isa_iow_n;
    assign io_cycle = !isa_ior_n || !isa_iow_n;
    assign mem_cycle = !isa_memr_n || (!isa_memw_n && bios_write_enable);

    // ==========================================================
    // Strap capture
    // ==========================================================
    logic strap_done_reg;
    logic kb_enable_reg;
    logic rtc_enable_reg;
    logic rom_strap_reg;
    logic aux_25m_reg;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            strap_done_reg <= 1'b0;
            kb_enable_reg <= 1'b0;
            rtc_enable_reg <= 1'b0;
            rom_strap_reg <= 1'b0;
            aux_25m_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            kb_enable_reg <= !post_pin_in;
            rtc_enable_reg <= !clock_strap_n;
            rom_strap_reg <= rom_pin_in;
            aux_25m_reg <= !aux_clock_pin_in;
        end
    end

    assign aux_clock_select_25m = aux_25m_reg;

    // ==========================================================
    // Function selection
    // ==========================================================
    logic [PIN_COUNT-1:0] alt_sel;
    assign alt_sel[PIN_KB_IRQ] = kb_enable_reg;
    assign alt_sel[PIN_KB_SEL] = kb_enable_reg;
    assign alt_sel[PIN_AUX_SEL] = kb_enable_reg;
    assign alt_sel[PIN_PROG_IRQ] = gpio_activation_enable && prog_irq_select;
    assign alt_sel[PIN_POWER_LED] = gpio_activation_enable && power_indicator_select;
    assign alt_sel[PIN_RTC_IRQ] = rtc_enable_reg;
    assign alt_sel[PIN_RTC_SEL] = rtc_enable_reg;
    assign alt_sel[PIN_LOW_IO] = gpio_activation_enable && low_io_select_enable;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pin_function_status <= PIN_STATUS_RESET;
        end else begin
            pin_function_status <= alt_sel & {PIN_COUNT{strap_done_reg}};
        end
    end

    // ==========================================================
    // Chip select decode
    // ==========================================================
    logic post_sel_reg;
    logic rom_sel_reg;
    logic kb_sel_reg;
    logic aux_sel_reg;
    logic rtc_sel_reg;
    logic low_io_sel_reg;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            post_sel_reg <= SELECT_IDLE;
            rom_sel_reg <= SELECT_IDLE;
            kb_sel_reg <= SELECT_IDLE;
            aux_sel_reg <= SELECT_IDLE;
            rtc_sel_reg <= SELECT_IDLE;
            low_io_sel_reg <= SELECT_IDLE;
        end else begin
            post_sel_reg <= !(io_write && io_match(isa_addr, POST_PORT_ADDR));
            rom_sel_reg <= !((rom_decode_enable || rom_strap_reg) && mem_cycle
                             && bios_match(isa_addr, bios_range_sel));
            kb_sel_reg <= !(io_cycle && (io_match(isa_addr, KBC_DATA_ADDR)
                            || io_match(isa_addr, KBC_CMD_ADDR)));
            aux_sel_reg <= !(io_cycle && (io_match(isa_addr, AUX_DATA_ADDR)
                             || io_match(isa_addr, AUX_CMD_ADDR)));
            rtc_sel_reg <= !(io_cycle && (io_match(isa_addr, RTC_INDEX_ADDR)
                             || io_match(isa_addr, RTC_DATA_ADDR)));
            low_io_sel_reg <= !(io_cycle
                                && (isa_addr[LOW_IO_TOP_BIT:LOW_IO_BOT_BIT] == 5'h00));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            post_pin_out <= SELECT_IDLE;
            post_pin_oe <= 1'b0;
            rom_pin_out <= SELECT_IDLE;
            rom_pin_oe <= 1'b0;
        end else begin
            post_pin_out <= post_sel_reg;
            post_pin_oe <= strap_done_reg;
            rom_pin_out <= rom_sel_reg;
            rom_pin_oe <= strap_done_reg;
        end
    end

    // ==========================================================
    // Power indicator
    // ==========================================================
    logic power_led_reg;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            power_led_reg <= POWER_LED_RESET;
        end else if (power_indicator_write) begin
            power_led_reg <= power_indicator_level;
        end
    end

    // ==========================================================
    // Pin drivers and forwarded interrupts
    // ==========================================================
    logic [PIN_COUNT-1:0] alt_value;
    logic [PIN_COUNT-1:0] alt_drive;
    assign alt_value = {low_io_sel_reg, rtc_sel_reg, 1'b1, power_led_reg,
                        1'b1, aux_sel_reg, kb_sel_reg, 1'b1};
    assign alt_drive = 8'h D6;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    gpio_pin_out[gi] <= 1'b1;
                    gpio_pin_oe[gi] <= 1'b0;
                end else if (!strap_done_reg) begin
                    gpio_pin_out[gi] <= 1'b1;
                    gpio_pin_oe[gi] <= 1'b0;
                end else if (alt_sel[gi]) begin
                    gpio_pin_out[gi] <= alt_value[gi];
                    gpio_pin_oe[gi] <= alt_drive[gi];
                end else begin
                    gpio_pin_out[gi] <= gpio_out_value[gi];
                    gpio_pin_oe[gi] <= gpio_activation_enable
                                       && gpio_drive_enable[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            gpio_in_value <= '0;
            keyboard_irq_out <= 1'b0;
            clock_irq_out <= 1'b0;
            programmable_irq_input <= 1'b0;
        end else begin
            gpio_in_value <= gpio_pin_in & ~alt_sel
                             & {PIN_COUNT{gpio_activation_enable}};
            keyboard_irq_out <= alt_sel[PIN_KB_IRQ] && gpio_pin_in[PIN_KB_IRQ];
            clock_irq_out <= alt_sel[PIN_RTC_IRQ] && gpio_pin_in[PIN_RTC_IRQ];
            programmable_irq_input <= alt_sel[PIN_PROG_IRQ]
                                      && gpio_pin_in[PIN_PROG_IRQ];
        end
    end

    // ==========================================================
    // Reference clock buffers
    // ==========================================================
    assign ref_clock_buffer_out = ref_clock_in;
    assign ref_clock_buffer_out_2 = ref_clock_in;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    AST_POST_WRITE_ONLY: assert property (
        !post_sel_reg |-> $past(!isa_iow_n) && ($past(isa_addr[15:0]) == POST_PORT_ADDR))
        else $error("post select without write to port 80");
    AST_KB_STRAP_HELD: assert property (
        strap_done_reg && $past(strap_done_reg) |-> $stable(kb_enable_reg) && $stable(rtc_enable_reg))
        else $error("strap value changed after capture");
    AST_ROM_NEEDS_ENABLE: assert property (
        !rom_sel_reg |-> $past(rom_decode_enable) || rom_strap_reg)
        else $error("rom select without enable");
    AST_KB_PIN_DRIVE: assert property (
        kb_enable_reg && strap_done_reg ##1 1 |-> gpio_pin_out[PIN_KB_SEL] == $past(kb_sel_reg))
        else $error("keyboard select not on pin 1");
    AST_RTC_DECODE: assert property (
        !isa_ior_n && isa_addr[15:0] == RTC_DATA_ADDR |=> !rtc_sel_reg)
        else $error("rtc select missed at 71h");
    AST_LOW_IO_DECODE: assert property (
        !isa_iow_n && isa_addr[15:11] == 5'h00 |=> !low_io_sel_reg)
        else $error("low io select missed");
    AST_LED_HOLD: assert property (
        !power_indicator_write |=> power_led_reg == $past(power_led_reg))
        else $error("power indicator changed without write");
    AST_SELECT_IDLE: assert property (
        isa_ior_n && isa_iow_n && isa_memr_n && isa_memw_n |=> kb_sel_reg && aux_sel_reg
            && rtc_sel_reg && low_io_sel_reg && post_sel_reg && rom_sel_reg)
        else $error("select active with no command");
    AST_STATUS_MATCH: assert property (
        strap_done_reg |=> pin_function_status == $past(alt_sel))
        else $error("function status mismatch");
    AST_GPIO_IDLE: assert property (
        !gpio_activation_enable && !alt_sel[PIN_LOW_IO] |=> !gpio_pin_oe[PIN_LOW_IO])
        else $error("pin 7 driven while inactive");

    COV_POST: cover property (!isa_iow_n && isa_addr[15:0] == POST_PORT_ADDR ##1 !post_sel_reg);
    COV_KB: cover property (kb_enable_reg ##1 !kb_sel_reg);
    COV_ROM: cover property (!rom_sel_reg);
    COV_LED: cover property (power_indicator_write && power_indicator_level ##1 power_led_reg);

endmodule : lcs_pin_mux

// file: sim/lcs_isa_periph.sv
`timescale 1ns/1ps
// ==========================================================
// Board straps and legacy peripherals on the muxed pins
// ==========================================================
module lcs_isa_periph
    import lcs_pkg::*;
(
    input wire logic kb_strap_fitted,
    input wire logic rom_strap_fitted,
    input wire logic rtc_strap_fitted,
    input wire logic lan_clock_fitted,
    input wire logic [2:0] irq_level,
    input wire logic post_pin_out,
    input wire logic post_pin_oe,
    input wire logic rom_pin_out,
    input wire logic rom_pin_oe,
    input wire logic [PIN_COUNT-1:0] gpio_pin_out,
    input wire logic [PIN_COUNT-1:0] gpio_pin_oe,
    output logic post_pin_in,
    output logic rom_pin_in,
    output logic clock_strap_n,
    output logic aux_clock_pin_in,
    output logic [PIN_COUNT-1:0] gpio_pin_in
);
    logic [PIN_COUNT-1:0] far_level;

    // Undriven pins float to their pull-ups unless a peripheral drives an irq
    always_comb begin
        far_level = 8'hFF;
        far_level[PIN_KB_IRQ] = irq_level[0];
        far_level[PIN_PROG_IRQ] = irq_level[1];
        far_level[PIN_RTC_IRQ] = irq_level[2];
    end

    // Weak internal pull-up, fitted pull-down wins
    assign post_pin_in = post_pin_oe ? post_pin_out : !kb_strap_fitted;
    // Pull-up when a boot ROM is fitted, board pull-down otherwise
    assign rom_pin_in = rom_pin_oe ? rom_pin_out : rom_strap_fitted;
    assign clock_strap_n = !rtc_strap_fitted;
    assign aux_clock_pin_in = !lan_clock_fitted;
    assign gpio_pin_in = (gpio_pin_oe & gpio_pin_out) | (~gpio_pin_oe & far_level);
endmodule : lcs_isa_periph

// file: sim/lcs_pin_mux_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module lcs_pin_mux_bench
    import lcs_pkg::*;
;
    logic clk_sys, reset_n, ref_clock_in, isa_ior_n, isa_iow_n, isa_memr_n, isa_memw_n;
    logic [ADDR_W-1:0] isa_addr;
    logic rom_decode_enable, bios_write_enable, gpio_activation_enable, low_io_select_enable;
    logic prog_irq_select, power_indicator_select, power_indicator_write, power_indicator_level;
    logic [1:0] bios_range_sel;
    logic [PIN_COUNT-1:0] gpio_out_value, gpio_drive_enable, gpio_pin_in, gpio_pin_out;
    logic [PIN_COUNT-1:0] gpio_pin_oe, gpio_in_value, pin_function_status;
    logic post_pin_in, post_pin_out, post_pin_oe, rom_pin_in, rom_pin_out, rom_pin_oe;
    logic clock_strap_n, aux_clock_pin_in, aux_clock_select_25m, keyboard_irq_out;
    logic clock_irq_out, programmable_irq_input, ref_clock_buffer_out, ref_clock_buffer_out_2;
    logic kb_fit, rom_fit, rtc_fit, lan_fit, kb_on, rom_on, rtc_on;
    logic [2:0] irq_level;
    logic [5:0] sel_now;
    int fail_count = 0;
    int n_compared = 0;
    logic [15:0] io_tab [10] = '{16'h0060, 16'h0064, 16'h0062, 16'h0066, 16'h0070,
                                 16'h0071, 16'h0080, 16'h0081, 16'h07FF, 16'h0800};
    logic [23:0] rom_tab [5] = '{24'h800000, 24'hC00000, 24'hE00000, 24'hF00000, 24'h7FFFFF};

    assign sel_now = {post_pin_out, rom_pin_out, gpio_pin_out[7], gpio_pin_out[6],
                      gpio_pin_out[2], gpio_pin_out[1]};

    lcs_pin_mux i_lcs_pin_mux (.clk_sys, .reset_n, .isa_addr, .isa_ior_n, .isa_iow_n,
        .isa_memr_n, .isa_memw_n, .rom_decode_enable, .bios_range_sel, .bios_write_enable,
        .gpio_activation_enable, .low_io_select_enable, .prog_irq_select,
        .power_indicator_select, .power_indicator_write, .power_indicator_level,
        .gpio_out_value, .gpio_drive_enable, .post_pin_in, .post_pin_out, .post_pin_oe,
        .rom_pin_in, .rom_pin_out, .rom_pin_oe, .clock_strap_n, .aux_clock_pin_in,
        .aux_clock_select_25m, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe, .gpio_in_value,
        .pin_function_status, .keyboard_irq_out, .clock_irq_out, .programmable_irq_input,
        .ref_clock_in, .ref_clock_buffer_out, .ref_clock_buffer_out_2);

    lcs_isa_periph i_lcs_isa_periph (.kb_strap_fitted(kb_fit), .rom_strap_fitted(rom_fit),
        .rtc_strap_fitted(rtc_fit), .lan_clock_fitted(lan_fit), .irq_level, .post_pin_out,
        .post_pin_oe, .rom_pin_out, .rom_pin_oe, .gpio_pin_out, .gpio_pin_oe, .post_pin_in,
        .rom_pin_in, .clock_strap_n, .aux_clock_pin_in, .gpio_pin_in);

    // ==========================================================
    // Clocks and watchdog
    // ==========================================================
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        ref_clock_in = 1'b0;
        forever #34.92 ref_clock_in = ~ref_clock_in;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        end_sim();
    end

    // ==========================================================
    // Expected selects {post, rom, pin7, pin6, pin2, pin1}
    // ==========================================================
    function automatic logic [5:0] exp_sel(input logic [23:0] a, input logic [3:0] cmd);
        logic io;
        logic hit;
        io = cmd[3] | cmd[2];
        case (bios_range_sel)
            2'h0: hit = a[23:20] == 4'hF;
            2'h1: hit = a[23:21] == 3'h7;
            2'h2: hit = a[23:22] == 2'h3;
            default: hit = a[23];
        endcase
        hit = hit & (rom_decode_enable | rom_on) & (cmd[1] | (cmd[0] & bios_write_enable));
        exp_sel[5] = !(cmd[2] && a[15:0] == POST_PORT_ADDR);
        exp_sel[4] = !hit;
        exp_sel[3] = !(io && gpio_activation_enable && low_io_select_enable
                       && a[LOW_IO_TOP_BIT:LOW_IO_BOT_BIT] == 5'h00);
        exp_sel[2] = !(io && rtc_on && (a[15:0] == RTC_INDEX_ADDR || a[15:0] == RTC_DATA_ADDR));
        exp_sel[1] = !(io && kb_on && (a[15:0] == AUX_DATA_ADDR || a[15:0] == AUX_CMD_ADDR));
        exp_sel[0] = !(io && kb_on && (a[15:0] == KBC_DATA_ADDR || a[15:0] == KBC_CMD_ADDR));
    endfunction : exp_sel

    // One ISA command, cmd = {ior, iow, memr, memw} active high
    task automatic io(input logic [23:0] a, input logic [3:0] cmd);
        logic [5:0] m;
        m = (gpio_activation_enable && low_io_select_enable) ? 6'h3F : 6'h37;
        isa_addr = a;
        {isa_ior_n, isa_iow_n, isa_memr_n, isa_memw_n} = ~cmd;
        repeat (4) @(negedge clk_sys);
        `CHK(sel_now & m, exp_sel(a, cmd) & m)
        {isa_ior_n, isa_iow_n, isa_memr_n, isa_memw_n} = 4'hF;
        repeat (4) @(negedge clk_sys);
        `CHK(sel_now & m, 6'h3F & m)
    endtask : io

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (16) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask : do_reset

    task automatic irq_check(input logic [2:0] lvl, input logic [2:0] exp);
        irq_level = lvl;
        repeat (3) @(negedge clk_sys);
        `CHK({programmable_irq_input, clock_irq_out, keyboard_irq_out}, exp)
    endtask : irq_check

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        reset_n = 1'b0;
        isa_addr = '0;
        {isa_ior_n, isa_iow_n, isa_memr_n, isa_memw_n} = 4'hF;
        {rom_decode_enable, bios_write_enable, gpio_activation_enable} = 3'h0;
        {low_io_select_enable, prog_irq_select, power_indicator_select} = 3'h7;
        {power_indicator_write, power_indicator_level} = 2'h0;
        bios_range_sel = BIOS_RANGE_8MB;
        gpio_out_value = 8'hFF;
        gpio_drive_enable = 8'hFE;
        irq_level = 3'h0;
        {kb_fit, rom_fit, rtc_fit, lan_fit, kb_on, rom_on, rtc_on} = 7'h7F;
        do_reset();
        `CHK(pin_function_status, 8'h67)
        `CHK(aux_clock_select_25m, 1'b1)
        `CHK({gpio_pin_oe, gpio_in_value}, {8'h46, 8'h00})
        `CHK({post_pin_oe, rom_pin_oe}, 2'h3)
        {kb_fit, rtc_fit, lan_fit} = 3'h0;
        repeat (4) @(negedge clk_sys);
        `CHK({pin_function_status, aux_clock_select_25m}, {8'h67, 1'b1})
        foreach (io_tab[i]) begin
            io({8'h00, io_tab[i]}, 4'b1000);
            io({8'h00, io_tab[i]}, 4'b0100);
        end
        $display("io decode with straps done");
        for (int r = 0; r < 4; r++) begin
            bios_range_sel = r[1:0];
            foreach (rom_tab[j]) io(rom_tab[j], 4'b0010);
        end
        io(24'hFFFFF0, 4'b0001);
        bios_write_enable = 1'b1;
        io(24'hFFFFF0, 4'b0001);
        bios_write_enable = 1'b0;
        $display("rom decode done");
        irq_check(3'b111, 3'b011);
        irq_check(3'b000, 3'b000);
        gpio_activation_enable = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK(pin_function_status, 8'hFF)
        `CHK(gpio_pin_out[PIN_POWER_LED], POWER_LED_RESET)
        irq_check(3'b010, 3'b100);
        power_indicator_level = 1'b1;
        power_indicator_write = 1'b1;
        @(negedge clk_sys);
        power_indicator_write = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK(gpio_pin_out[PIN_POWER_LED], 1'b1)
        io(24'h0007FF, 4'b1000);
        io(24'h000800, 4'b0100);
        io(24'h000064, 4'b0100);
        $display("software functions done");
        {kb_fit, rom_fit, rtc_fit, lan_fit, kb_on, rom_on, rtc_on} = 7'h00;
        {prog_irq_select, power_indicator_select} = 2'h0;
        do_reset();
        `CHK(pin_function_status, 8'h80)
        `CHK(aux_clock_select_25m, 1'b0)
        irq_check(3'b111, 3'b000);
        `CHK(gpio_in_value, 8'h7F)
        `CHK(gpio_pin_oe, 8'hFE)
        gpio_out_value = 8'h55;
        repeat (4) @(negedge clk_sys);
        `CHK({gpio_pin_out, gpio_in_value}, {8'hD5, 8'h55})
        gpio_out_value = 8'hFF;
        io(24'h000064, 4'b1000);
        io(24'h000070, 4'b0100);
        io(24'hFFFFF0, 4'b0010);
        rom_decode_enable = 1'b1;
        io(24'hFFFFF0, 4'b0010);
        repeat (8) begin
            @(negedge clk_sys);
            #1;
            `CHK({ref_clock_buffer_out, ref_clock_buffer_out_2}, {2{ref_clock_in}})
        end
        $display("straps off and clock buffer done");
        end_sim();
    end
endmodule : lcs_pin_mux_bench
